// ==== scr_secure_config.sv ====
`timescale 1ns/1ps
module ssr_secure_config (
   // clock and reset
   input  wire logic              ref_clk,
   input  wire logic              rstn,
   input  wire logic              clk_en,
   // processor mode and state
   input  wire logic [4:0]        cur_mode,
   // coprocessor move port
   input  wire ssr_pkg::ssr_req_t req,
   output ssr_pkg::ssr_rsp_t      rsp,
   // exception events
   input  wire logic              ext_abort_evt,
   // control to the core
   output ssr_pkg::ssr_ctl_t      ctl
);
   import ssr_pkg::*;

   // whole block state and its next value
   ssr_state_t            s_q;
   ssr_state_t            s_d;

   // decode of the move coordinates
   logic                  cp_match;
   logic                  opc1_match;
   logic                  crn_match;
   logic                  crm_match;
   logic                  opc2_match;
   logic                  hit;

   // access permission of the current move
   logic                  in_monitor;
   logic                  in_user;
   logic                  cur_nonsecure;
   logic                  secure_priv;
   logic                  take_write;
   logic                  take_read;

   // register value with this cycle's write applied
   logic [SSR_IMPL_W-1:0] cfg_next;

   // derived control levels, from the merged value except fault_secure, which uses the held value
   logic                  nonsec_next;
   logic                  may_chg_abort;
   logic                  may_chg_fast;
   logic                  fault_secure;

   // ------------------------------------------------------------------
   // timing overview
   // a move present at edge k is answered by a done pulse after edge k,
   // so the core sees done, undef and read data one cycle after the
   // request. control levels move on that same edge, so a routing change
   // and its write acknowledge become visible together. nothing here
   // waits on the core: back to back moves are taken one per cycle.
   // clk_en low freezes every flop, answers included, so a pulse
   // simply stretches while the enable is low.
   // ------------------------------------------------------------------

   // move coordinate decode; any other coordinate is another register
   assign cp_match   = req.cp_num == SSR_CP_NUM;
   assign opc1_match = req.opc1 == SSR_OPC1;
   assign crn_match  = req.crn == SSR_CRN;
   assign crm_match  = req.crm == SSR_CRM;
   assign opc2_match = req.opc2 == SSR_OPC2;

   // a hit needs every coordinate; misses get no answer at all
   assign hit = req.valid
                && cp_match
                && opc1_match
                && crn_match
                && crm_match
                && opc2_match;

   // mode decode for the access check
   assign in_monitor = cur_mode == SSR_MODE_MON;
   assign in_user    = cur_mode == SSR_MODE_USR;

   // monitor mode is always secure; elsewhere the state bit decides.
   // the held value is used, so a write that sets the state bit only
   // locks out moves from the following cycle on
   assign cur_nonsecure = !in_monitor && s_q.cfg[SSR_NONSEC_BIT];
   assign secure_priv   = !in_user && !cur_nonsecure;

   // accepted moves; refused ones change nothing
   assign take_write = hit && secure_priv && req.write;
   assign take_read  = hit && secure_priv && !req.write;

   // per bit merge of write data and held value; only the implemented
   // low bits have flops, so upper write data is dropped here
   for (genvar i = 0; i < SSR_IMPL_W; i++) begin : g_bit
      assign cfg_next[i] = take_write ? req.wdata[i] : s_q.cfg[i];
   end

   // security state as the core will see it after this edge
   assign nonsec_next = !in_monitor && cfg_next[SSR_NONSEC_BIT];

   // secure code may always change the masks; nonsecure code only when
   // the matching writable bit is set
   assign may_chg_abort = !nonsec_next
                          || cfg_next[SSR_ABT_WR_BIT];
   assign may_chg_fast  = !nonsec_next
                          || cfg_next[SSR_FAST_WR_BIT];

   // an abort taken while routed to the monitor logs in secure copies.
   // the held routing bit is used, since the abort was routed with it
   assign fault_secure = ext_abort_evt
                         && s_q.cfg[SSR_ABT_ROUTE_BIT];

   // next state: answer, register and control levels
   always_comb begin
      s_d = s_q;
      // answer pulse, one cycle after every decoded move
      s_d.rsp.done  = hit;
      s_d.rsp.undef = hit && !secure_priv;
      s_d.rsp.rdata = '0;
      if (take_read) begin
         // unimplemented bits read as zero
         s_d.rsp.rdata = SSR_DATA_W'(s_q.cfg);
      end
      // register keeps its value unless a write was accepted
      s_d.cfg = cfg_next;
      // permission levels for the status register mask bits
      s_d.ctl.abort_mask_writable    = cfg_next[SSR_ABT_WR_BIT];
      s_d.ctl.fast_irq_mask_writable = cfg_next[SSR_FAST_WR_BIT];
      // pair settings are left to software; hardware does not police
      // them, since any combination is a legal register value
      s_d.ctl.ext_abort_to_monitor =
         cfg_next[SSR_ABT_ROUTE_BIT];
      s_d.ctl.fast_irq_to_monitor  =
         cfg_next[SSR_FAST_ROUTE_BIT];
      s_d.ctl.irq_to_monitor       =
         cfg_next[SSR_IRQ_ROUTE_BIT];
      // state bit outside monitor mode, bank select inside it
      s_d.ctl.nonsecure_state_bit  = nonsec_next;
      s_d.ctl.bank_sel_nonsecure   =
         cfg_next[SSR_NONSEC_BIT];
      // mask change permissions for the status register logic
      s_d.ctl.nonsec_may_chg_abort = may_chg_abort;
      s_d.ctl.nonsec_may_chg_fast  = may_chg_fast;
      // one cycle strobe to the fault status and address logic
      s_d.ctl.fault_to_secure_copy = fault_secure;
   end

   // single state register, frozen while clk_en is low.
   // reset leaves the core secure, so both masks stay changeable
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         s_q                          <= '0;
         s_q.cfg                      <= SSR_RESET;
         s_q.ctl.nonsec_may_chg_abort <= 1'b1;
         s_q.ctl.nonsec_may_chg_fast  <= 1'b1;
      end else if (clk_en) begin
         s_q <= s_d;
      end
   end

   // outputs come straight from the state flops
   assign rsp = s_q.rsp;
   assign ctl = s_q.ctl;

   // ------------------------------------------------------------------
   // limitations
   // the mode encodings for monitor and user mode are a local choice;
   // every other mode counts as privileged. the block does not see the
   // mask bits themselves, only grants permission to change them.
   // the fault strobe says where to log, not what; the fault status
   // and address registers live elsewhere and latch on this strobe.
   // reserved bits have no flops at all, which keeps them at zero even
   // if a write arrives during the cycle that reset is released.
   // an access refused for lack of privilege still answers with done,
   // so the pipeline can retire the move into the undefined trap.
   // ------------------------------------------------------------------
endmodule

// ==== scr_pkg.sv ====
package ssr_pkg;
   // coprocessor move coordinates of this register
   localparam logic [3:0] SSR_CP_NUM         = 4'hf;
   localparam logic [2:0] SSR_OPC1           = 3'h0;
   localparam logic [3:0] SSR_CRN            = 4'h1;
   localparam logic [3:0] SSR_CRM            = 4'h1;
   localparam logic [2:0] SSR_OPC2           = 3'h0;
   // bit positions inside the register
   localparam int         SSR_ABT_WR_BIT     = 5;
   localparam int         SSR_FAST_WR_BIT    = 4;
   localparam int         SSR_ABT_ROUTE_BIT  = 3;
   localparam int         SSR_FAST_ROUTE_BIT = 2;
   localparam int         SSR_IRQ_ROUTE_BIT  = 1;
   localparam int         SSR_NONSEC_BIT     = 0;
   // implemented width, full data width, reset value
   localparam int         SSR_IMPL_W         = 6;
   localparam int         SSR_DATA_W         = 32;
   localparam logic [5:0] SSR_RESET          = 6'h00;
   // processor mode encodings used by the access check
   localparam logic [4:0] SSR_MODE_MON       = 5'h16;
   localparam logic [4:0] SSR_MODE_USR       = 5'h10;

   // coprocessor move request from the pipeline
   typedef struct packed {
      logic                  valid;
      logic                  write;
      logic [3:0]            cp_num;
      logic [2:0]            opc1;
      logic [3:0]            crn;
      logic [3:0]            crm;
      logic [2:0]            opc2;
      logic [SSR_DATA_W-1:0] wdata;
   } ssr_req_t;

   // answer to a coprocessor move
   typedef struct packed {
      logic                  done;
      logic                  undef;
      logic [SSR_DATA_W-1:0] rdata;
   } ssr_rsp_t;

   // routing and permission outputs to the exception logic
   typedef struct packed {
      logic abort_mask_writable;
      logic fast_irq_mask_writable;
      logic ext_abort_to_monitor;
      logic fast_irq_to_monitor;
      logic irq_to_monitor;
      logic nonsecure_state_bit;
      logic bank_sel_nonsecure;
      logic nonsec_may_chg_abort;
      logic nonsec_may_chg_fast;
      logic fault_to_secure_copy;
   } ssr_ctl_t;

   // all state of the block
   typedef struct packed {
      logic [SSR_IMPL_W-1:0] cfg;
      ssr_rsp_t              rsp;
      ssr_ctl_t              ctl;
   } ssr_state_t;
endpackage

// ==== scr_chk_sva.sv ====
`timescale 1ns/1ps
module ssr_chk (
   // clock and reset
   input wire logic              ref_clk,
   input wire logic              rstn,
   input wire logic              clk_en,
   // watched inputs
   input wire logic              ext_abort_evt,
   input wire logic [4:0]        cur_mode,
   input wire ssr_pkg::ssr_req_t req,
   // watched outputs
   input wire ssr_pkg::ssr_rsp_t rsp,
   input wire ssr_pkg::ssr_ctl_t ctl
);
   import ssr_pkg::*;
   logic hit;
   logic sp;
   logic wr;
   // decoded move, secure privileged, accepted write
   assign hit = clk_en && req.valid && req.cp_num == SSR_CP_NUM
                && req.opc1 == SSR_OPC1 && req.crn == SSR_CRN
                && req.crm == SSR_CRM && req.opc2 == SSR_OPC2;
   assign sp  = cur_mode != SSR_MODE_USR
                && (cur_mode == SSR_MODE_MON || !ctl.bank_sel_nonsecure);
   assign wr  = hit && sp && req.write;
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!rstn);
   property p_hit;
      hit |=> rsp.done;
   endproperty
   a_hit: assert property (p_hit) else $error("no answer");
   property p_und;
      hit && !sp |=> rsp.undef;
   endproperty
   a_und: assert property (p_und) else $error("no trap");
   property p_raz;
      rsp.done |-> rsp.rdata[SSR_DATA_W-1:SSR_IMPL_W] == '0;
   endproperty
   a_raz: assert property (p_raz) else $error("upper bits set");
   property p_aw;
      wr |=> ctl.abort_mask_writable == $past(req.wdata[SSR_ABT_WR_BIT]);
   endproperty
   a_aw: assert property (p_aw) else $error("abort writable");
   property p_fw;
      wr |=> ctl.fast_irq_mask_writable
             == $past(req.wdata[SSR_FAST_WR_BIT]);
   endproperty
   a_fw: assert property (p_fw) else $error("fast writable");
   property p_ea;
      wr |=> ctl.ext_abort_to_monitor
             == $past(req.wdata[SSR_ABT_ROUTE_BIT]);
   endproperty
   a_ea: assert property (p_ea) else $error("abort route");
   property p_fq;
      wr |=> ctl.fast_irq_to_monitor
             == $past(req.wdata[SSR_FAST_ROUTE_BIT]);
   endproperty
   a_fq: assert property (p_fq) else $error("fast route");
   property p_iq;
      wr |=> ctl.irq_to_monitor == $past(req.wdata[SSR_IRQ_ROUTE_BIT]);
   endproperty
   a_iq: assert property (p_iq) else $error("irq route");
   property p_ns;
      wr |=> ctl.bank_sel_nonsecure == $past(req.wdata[SSR_NONSEC_BIT]);
   endproperty
   a_ns: assert property (p_ns) else $error("state select");
   property p_ma;
      ctl.nonsec_may_chg_abort
         == (!ctl.nonsecure_state_bit || ctl.abort_mask_writable);
   endproperty
   a_ma: assert property (p_ma) else $error("abort permit");
   property p_fa;
      clk_en && ext_abort_evt && ctl.ext_abort_to_monitor
         |=> ctl.fault_to_secure_copy;
   endproperty
   a_fa: assert property (p_fa) else $error("fault copy");
   property p_st;
      ctl.nonsecure_state_bit |-> ctl.bank_sel_nonsecure;
   endproperty
   a_st: assert property (p_st) else $error("state bit");
endmodule

// ==== testbench.sv ====
`timescale 1ns/1ps
module testbench;
   import ssr_pkg::*;
   logic        ref_clk = 0, rstn = 0, clk_en = 1, abt = 0;
   logic [4:0]  mode = SSR_MODE_MON;
   logic [4:0]  md_t[3] = '{SSR_MODE_MON, SSR_MODE_USR, 5'h13};
   logic [5:0]  m = 6'h00;
   logic [31:0] r = 32'h3b65dd01;
   logic [42:0] q[$];
   logic [42:0] ex;
   int          mismatches = 0, n_compared = 0, cyc = 0;
   ssr_req_t    req = '0;
   ssr_rsp_t    rsp;
   ssr_ctl_t    ctl;
   ssr_secure_config dut (.ref_clk, .rstn, .clk_en, .cur_mode(mode), .req,
      .rsp, .ext_abort_evt(abt), .ctl);
   initial forever #2.5 ref_clk = ~ref_clk;
   function logic [31:0] xs();
      r ^= r << 13;
      r ^= r >> 17;
      r ^= r << 5;
      return r;
   endfunction
   task chk(logic [63:0] s, e);
      n_compared++;
      if (s !== e) begin
         mismatches++;
         $display("wrong value %0t %h %h", $time, s, e);
      end
   endtask
   task final_report();
      $display("compared %0d mismatches %0d", n_compared, mismatches);
      if (mismatches == 0 && n_compared > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   // back to back moves; a crm of zero must be ignored
   task acc(logic w, logic [4:0] md, logic [3:0] c, logic [31:0] d);
      logic       sp, ns;
      logic [5:0] o;
      ssr_ctl_t   e;
      @(posedge ref_clk);
      if (w) begin
         d[4] = !d[2];
         d[5] = !d[3];
      end
      mode <= md;
      req <= {1'b1, w, SSR_CP_NUM, SSR_OPC1, SSR_CRN, c, SSR_OPC2, d};
      abt <= d[7];
      o = m;
      sp = md != SSR_MODE_USR && (md == SSR_MODE_MON || !o[0]);
      if (c == SSR_CRM && sp && w) m = d[5:0];
      ns = md != SSR_MODE_MON && m[0];
      e = '{m[5], m[4], m[3], m[2], m[1], ns, m[0], !ns || m[5],
            !ns || m[4], d[7] && o[3]};
      if (c == SSR_CRM) q.push_back({!sp, (sp && !w) ? {26'h0, o} : 32'h0, e});
   endtask
   // answers compared oldest first; timeout guards a hang
   always @(posedge ref_clk) begin
      cyc++;
      if (cyc > 1000) begin
         mismatches++;
         final_report();
      end else if (rsp.done === 1'b1) begin
         ex = q.size() ? q.pop_front() : '1;
         chk({rsp.undef, rsp.rdata, ctl}, ex);
      end
   end
   initial begin
      repeat (12) @(posedge ref_clk);
      rstn <= 1;
      acc(0, SSR_MODE_MON, SSR_CRM, 0);
      repeat (60) begin
         acc(1, md_t[xs() % 3], SSR_CRM, xs());
         acc(0, md_t[xs() % 3], 4'(xs() % 2), 0);
      end
      @(posedge ref_clk);
      req.valid <= 0;
      repeat (3) @(posedge ref_clk);
      chk(64'(q.size()), 0);
      // mid-run reset: register cleared, only mask permissions high
      rstn <= 0;
      m = 6'h00;
      @(posedge ref_clk);
      chk({rsp, ctl}, {34'h0, 10'h006});
      rstn <= 1;
      acc(0, SSR_MODE_MON, SSR_CRM, 0);
      @(posedge ref_clk);
      req.valid <= 0;
      repeat (3) @(posedge ref_clk);
      chk(64'(q.size()), 0);
      final_report();
   end
endmodule
bind ssr_secure_config ssr_chk chk (.ref_clk, .rstn, .clk_en, .cur_mode,
   .req, .rsp, .ext_abort_evt, .ctl);
